// ---- inc/nor_host_defs.svh ----
// timing counts, field positions and reset values for the parallel nor host controller
`ifndef NOR_HOST_DEFS_SVH
`define NOR_HOST_DEFS_SVH

// ****************************************
// bus and address fields
// ****************************************
`define NOR_DATA_W        16
`define NOR_ADDR_W        26
`define NOR_PAGE_LOW_W    4
`define NOR_PAGE_WORDS    16
`define NOR_WBUF_LOW_W    8
`define NOR_ERASED_WORD   16'hffff
`define NOR_CMD_READ      1'b0
`define NOR_CMD_WRITE     1'b1

// ****************************************
// timing, clock 25 mhz
// ****************************************
`define NOR_CLK_MHZ       25
`define NOR_T_ACC_NS      120
`define NOR_T_PACC_NS     15
`define NOR_T_WP_NS       35
`define NOR_T_WPH_NS      20
// least times round up to whole cycles
`define NOR_CYC_ACC       ((`NOR_T_ACC_NS * `NOR_CLK_MHZ + 999) / 1000)
`define NOR_CYC_PACC      ((`NOR_T_PACC_NS * `NOR_CLK_MHZ + 999) / 1000)
`define NOR_CYC_WP        ((`NOR_T_WP_NS * `NOR_CLK_MHZ + 999) / 1000)
`define NOR_CYC_WPH       ((`NOR_T_WPH_NS * `NOR_CLK_MHZ + 999) / 1000)

`endif

// ---- inc/nor_host_pkg.sv ----
// types shared by the parallel nor host controller
package nor_host_pkg;

  // gray codes along the read path; write states are gray only among themselves, entering and leaving them flips two bits
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_RD_INIT = 3'h1,
    ST_RD_PAGE = 3'h3,
    ST_RD_LAST = 3'h2,
    ST_RD_HIT  = 3'h4,
    ST_WR_SET  = 3'h6,
    ST_WR_PUL  = 3'h7,
    ST_WR_HOLD = 3'h5
  } state_t;

endpackage

// ---- design/nor_page_store.sv ----
// small word memory with registered read data, holds the last fetched page
`timescale 1ns/100ps
module nor_page_store #(
  parameter int DATA_W = 16,
  parameter int DEPTH  = 16,
  parameter int IDX_W  = 4
) (
  input  wire logic              clk_i,
  input  wire logic              wr_en_i,
  input  wire logic [IDX_W-1:0]  wr_idx_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic [IDX_W-1:0]  rd_idx_i,
  output logic      [DATA_W-1:0] rd_data_o
);

  logic [DATA_W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH != (1 << IDX_W)) begin
      $error("nor_page_store: DEPTH must equal 2**IDX_W");
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_idx_i];
  end

endmodule

// ---- design/nor_host_ctrl.sv ----
// host side controller driving an asynchronous 16-bit parallel nor flash
// Operation
// [R1] every transfer moves 16 data bits; all addresses are word addresses
// [R2] a random read fetches the whole aligned 32-byte page of the word
// [R3] later words of that page come by fast page access on low 4 bits
// [R4] a change above the page field starts a new initial access
// [R5] write buffer word is the low 8 bits, the buffer line above that
// [R6] device interface delivers read data from the entered map, signals writes
// [R7] device stores each write transfer's address and data in command memory
// [R8] device checks command memory after each write and runs matching algorithm
// [R9] host issues commands only as plain write transfers of command codes
// [R10] device shows progress status while an algorithm runs
// [R11] erased bits read one; programming only turns ones into zeros
// [R12] only erase returns zeros to ones, on a whole aligned 128-KB sector
// [R13] host may load 1 to 256 buffer words at any positions first
// [R14] buffer programming fills one aligned 512-byte array line
// [R15] device programs a hidden ecc code per loaded 32-byte page
// [R16] device checks ecc and corrects one bit during each initial access
// [R17] write buffer refills with ones after reset and buffer operations
// [R18] buffer ones leave array bits unchanged during programming
// [R19] protected sectors are not altered by program or erase
// [R20] while an algorithm runs, reads return polling status everywhere
// [R21] while an algorithm runs, only suspend and status read are accepted
`timescale 1ns/100ps
`include "nor_host_defs.svh"
module nor_host_ctrl #(
  parameter int ADDR_W = `NOR_ADDR_W
) (
  input  wire logic                    CLK_I,
  input  wire logic                    RESET_N_I,
  // user command port
  input  wire logic                    CMD_VALID_I,
  input  wire logic                    CMD_WRITE_I,
  input  wire logic [ADDR_W-1:0]       CMD_ADDR_I,
  input  wire logic [`NOR_DATA_W-1:0]  CMD_WDATA_I,
  output logic                         CMD_READY_O,
  output logic                         DONE_O,
  output logic [`NOR_DATA_W-1:0]       RDATA_O,
  // flash pins
  output logic [ADDR_W-1:0]            FLASH_A_O,
  input  wire logic [`NOR_DATA_W-1:0]  FLASH_DQ_I,
  output logic [`NOR_DATA_W-1:0]       FLASH_DQ_O,
  output logic                         FLASH_DQ_OE_O,
  output logic                         FLASH_CE_N_O,
  output logic                         FLASH_OE_N_O,
  output logic                         FLASH_WE_N_O
);

  localparam int LOW_W  = `NOR_PAGE_LOW_W;
  localparam int PAGE_W = ADDR_W - LOW_W;

  initial begin
    if (ADDR_W < `NOR_WBUF_LOW_W + 1 || ADDR_W > `NOR_ADDR_W) begin
      $error("nor_host_ctrl: ADDR_W out of range");
    end
  end

  // ****************************************
  // state
  // ****************************************
  nor_host_pkg::state_t state_r, state_nxt;
  logic [7:0]              wait_r, wait_nxt;
  logic [LOW_W-1:0]        idx_r, idx_nxt;
  logic [LOW_W-1:0]        want_r, want_nxt;
  logic [PAGE_W-1:0]       page_r, page_nxt;
  logic                    page_ok_r, page_ok_nxt;
  logic                    ready_r, ready_nxt;
  logic                    done_r, done_nxt;
  logic [`NOR_DATA_W-1:0]  rdata_r, rdata_nxt;
  logic [`NOR_DATA_W-1:0]  grab_r, grab_nxt;
  logic [ADDR_W-1:0]       a_r, a_nxt;
  logic [`NOR_DATA_W-1:0]  dq_r, dq_nxt;
  logic                    dq_oe_r, dq_oe_nxt;
  logic                    ce_n_r, ce_n_nxt;
  logic                    oe_n_r, oe_n_nxt;
  logic                    we_n_r, we_n_nxt;
  logic                    st_wr;
  logic [LOW_W-1:0]        st_wr_idx;
  logic [LOW_W-1:0]        st_rd_idx;
  logic [`NOR_DATA_W-1:0]  st_rd_data;

  function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] a);
    page_of = a[ADDR_W-1:LOW_W];
  endfunction

  function automatic logic [LOW_W-1:0] low_of(input logic [ADDR_W-1:0] a);
    low_of = a[LOW_W-1:0];
  endfunction

  // ****************************************
  // page copy
  // ****************************************
  nor_page_store #(
    .DATA_W (`NOR_DATA_W),
    .DEPTH  (`NOR_PAGE_WORDS),
    .IDX_W  (LOW_W)
  ) u_page (
    .clk_i     (CLK_I),
    .wr_en_i   (st_wr),
    .wr_idx_i  (st_wr_idx),
    .wr_data_i (FLASH_DQ_I),
    .rd_idx_i  (st_rd_idx),
    .rd_data_o (st_rd_data)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_nxt   = state_r;
    wait_nxt    = wait_r;
    idx_nxt     = idx_r;
    want_nxt    = want_r;
    page_nxt    = page_r;
    page_ok_nxt = page_ok_r;
    ready_nxt   = 1'b0;
    done_nxt    = 1'b0;
    rdata_nxt   = rdata_r;
    grab_nxt    = grab_r;
    a_nxt       = a_r;
    dq_nxt      = dq_r;
    dq_oe_nxt   = dq_oe_r;
    ce_n_nxt    = ce_n_r;
    oe_n_nxt    = oe_n_r;
    we_n_nxt    = we_n_r;
    st_wr       = 1'b0;
    st_wr_idx   = idx_r;
    st_rd_idx   = want_r;
    case (state_r)
      nor_host_pkg::ST_IDLE: begin
        ready_nxt = 1'b1;
        if (CMD_VALID_I && ready_r) begin
          ready_nxt = 1'b0;
          want_nxt  = low_of(CMD_ADDR_I);
          if (CMD_WRITE_I == `NOR_CMD_WRITE) begin
            // command codes go out as ordinary write cycles  [R9]
            // any address passes, so 1 to 256 buffer loads are plain writes
            a_nxt     = CMD_ADDR_I; // [R13]
            dq_nxt    = CMD_WDATA_I; // [R1]
            dq_oe_nxt = 1'b1;
            ce_n_nxt  = 1'b0;
            oe_n_nxt  = 1'b1;
            // any write may start an algorithm and swap in polling status  [R20]
            page_ok_nxt = 1'b0;
            state_nxt   = nor_host_pkg::ST_WR_SET;
          end else if (page_ok_r && page_r == page_of(CMD_ADDR_I)) begin
            st_rd_idx = low_of(CMD_ADDR_I); // [R3]
            state_nxt = nor_host_pkg::ST_RD_HIT;
          end else begin
            // new page: full initial access from word 0  [R4]
            page_nxt    = page_of(CMD_ADDR_I);
            page_ok_nxt = 1'b0;
            idx_nxt     = '0;
            a_nxt       = {page_of(CMD_ADDR_I), {LOW_W{1'b0}}};
            ce_n_nxt    = 1'b0;
            oe_n_nxt    = 1'b0;
            dq_oe_nxt   = 1'b0;
            wait_nxt    = 8'(`NOR_CYC_ACC - 1);
            state_nxt   = nor_host_pkg::ST_RD_INIT;
          end
        end
      end
      nor_host_pkg::ST_RD_HIT: begin
        rdata_nxt = st_rd_data;
        done_nxt  = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = nor_host_pkg::ST_IDLE;
      end
      nor_host_pkg::ST_RD_INIT,
      nor_host_pkg::ST_RD_PAGE: begin
        if (wait_r != 8'h00) begin
          wait_nxt = wait_r - 8'h01;
        end else begin
          // every word of the page is captured  [R2]
          st_wr = 1'b1;
          if (idx_r == want_r) begin
            // held aside so read data only moves together with done
            grab_nxt = FLASH_DQ_I; // [R1]
          end
          if (idx_r == LOW_W'(`NOR_PAGE_WORDS - 1)) begin
            ce_n_nxt  = 1'b1;
            oe_n_nxt  = 1'b1;
            state_nxt = nor_host_pkg::ST_RD_LAST;
          end else begin
            // only the in-page bits move: fast page access  [R3]
            idx_nxt   = idx_r + LOW_W'(1);
            a_nxt     = {page_r, idx_r + LOW_W'(1)};
            wait_nxt  = 8'(`NOR_CYC_PACC - 1);
            state_nxt = nor_host_pkg::ST_RD_PAGE;
          end
        end
      end
      nor_host_pkg::ST_RD_LAST: begin
        page_ok_nxt = 1'b1;
        rdata_nxt   = grab_r;
        done_nxt    = 1'b1;
        ready_nxt   = 1'b1;
        state_nxt   = nor_host_pkg::ST_IDLE;
      end
      nor_host_pkg::ST_WR_SET: begin
        we_n_nxt  = 1'b0;
        wait_nxt  = 8'(`NOR_CYC_WP - 1);
        state_nxt = nor_host_pkg::ST_WR_PUL;
      end
      nor_host_pkg::ST_WR_PUL: begin
        if (wait_r != 8'h00) begin
          wait_nxt = wait_r - 8'h01;
        end else begin
          // address and data held past the rising write edge
          we_n_nxt  = 1'b1;
          wait_nxt  = 8'(`NOR_CYC_WPH - 1);
          state_nxt = nor_host_pkg::ST_WR_HOLD;
        end
      end
      nor_host_pkg::ST_WR_HOLD: begin
        if (wait_r != 8'h00) begin
          wait_nxt = wait_r - 8'h01;
        end else begin
          ce_n_nxt  = 1'b1;
          dq_oe_nxt = 1'b0;
          done_nxt  = 1'b1;
          ready_nxt = 1'b1;
          state_nxt = nor_host_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = nor_host_pkg::ST_IDLE;
        ce_n_nxt  = 1'b1;
        oe_n_nxt  = 1'b1;
        we_n_nxt  = 1'b1;
        dq_oe_nxt = 1'b0;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_r   <= nor_host_pkg::ST_IDLE;
      wait_r    <= 8'h00;
      idx_r     <= '0;
      want_r    <= '0;
      page_r    <= '0;
      page_ok_r <= 1'b0;
      ready_r   <= 1'b0;
      done_r    <= 1'b0;
      rdata_r   <= `NOR_ERASED_WORD;
      grab_r    <= `NOR_ERASED_WORD;
      a_r       <= '0;
      dq_r      <= '0;
      dq_oe_r   <= 1'b0;
      ce_n_r    <= 1'b1;
      oe_n_r    <= 1'b1;
      we_n_r    <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      wait_r    <= wait_nxt;
      idx_r     <= idx_nxt;
      want_r    <= want_nxt;
      page_r    <= page_nxt;
      page_ok_r <= page_ok_nxt;
      ready_r   <= ready_nxt;
      done_r    <= done_nxt;
      rdata_r   <= rdata_nxt;
      grab_r    <= grab_nxt;
      a_r       <= a_nxt;
      dq_r      <= dq_nxt;
      dq_oe_r   <= dq_oe_nxt;
      ce_n_r    <= ce_n_nxt;
      oe_n_r    <= oe_n_nxt;
      we_n_r    <= we_n_nxt;
    end
  end

  assign CMD_READY_O   = ready_r;
  assign DONE_O        = done_r;
  assign RDATA_O       = rdata_r;
  assign FLASH_A_O     = a_r;
  assign FLASH_DQ_O    = dq_r;
  assign FLASH_DQ_OE_O = dq_oe_r;
  assign FLASH_CE_N_O  = ce_n_r;
  assign FLASH_OE_N_O  = oe_n_r;
  assign FLASH_WE_N_O  = we_n_r;

endmodule

// ---- tb/nor_host_sva.sv ----
// concurrent checks on the nor host controller ports
`timescale 1ns/100ps
module nor_host_sva #(
  parameter int ADDR_W = 26
) (
  input wire logic              CLK_I,
  input wire logic              RESET_N_I,
  input wire logic              CMD_VALID_I,
  input wire logic              CMD_WRITE_I,
  input wire logic [ADDR_W-1:0] CMD_ADDR_I,
  input wire logic [15:0]       CMD_WDATA_I,
  input wire logic              CMD_READY_O,
  input wire logic              DONE_O,
  input wire logic [15:0]       RDATA_O,
  input wire logic [ADDR_W-1:0] FLASH_A_O,
  input wire logic [15:0]       FLASH_DQ_O,
  input wire logic              FLASH_DQ_OE_O,
  input wire logic              FLASH_CE_N_O,
  input wire logic              FLASH_OE_N_O,
  input wire logic              FLASH_WE_N_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  wire logic take_w = CMD_VALID_I && CMD_READY_O;
  // ****************************************
  // write cycle steps
  // ****************************************
  sequence wr_setup;
    !FLASH_CE_N_O && FLASH_DQ_OE_O && FLASH_WE_N_O && FLASH_OE_N_O;
  endsequence
  sequence wr_pulse;
    !FLASH_WE_N_O ##1 FLASH_WE_N_O;
  endsequence
  sequence wr_end;
    DONE_O && FLASH_CE_N_O && !FLASH_DQ_OE_O;
  endsequence
  write_walk_a: assert property (take_w && CMD_WRITE_I |=> wr_setup ##1 wr_pulse ##[1:2] wr_end)
    else $error("write strobe sequence wrong");
  write_word_a: assert property (take_w && CMD_WRITE_I |=>
    FLASH_A_O == $past(CMD_ADDR_I) && FLASH_DQ_O == $past(CMD_WDATA_I))
    else $error("write address or data wrong");
  done_pulse_a: assert property (DONE_O |=> !DONE_O) else $error("done longer than one cycle");
  done_ready_a: assert property (DONE_O |-> CMD_READY_O) else $error("ready missing at done");
  take_busy_a: assert property (take_w |=> !CMD_READY_O) else $error("ready after take");
  idle_pins_a: assert property (CMD_READY_O |-> FLASH_CE_N_O && FLASH_WE_N_O)
    else $error("flash selected while idle");
  page_fetch_a: assert property ($fell(FLASH_OE_N_O) |-> FLASH_A_O[3:0] == 4'h0 ##19 DONE_O)
    else $error("page fetch length wrong");
  page_sweep_a: assert property ($fell(FLASH_OE_N_O) |-> ##3 FLASH_A_O[3:0] == 4'h1
    ##14 FLASH_A_O[3:0] == 4'hf) else $error("page word order wrong");
  page_hold_a: assert property ($fell(FLASH_OE_N_O) |=> $stable(FLASH_A_O[ADDR_W-1:4]) [*8])
    else $error("page field moved in fetch");
  no_fight_a: assert property (!FLASH_OE_N_O |-> !FLASH_DQ_OE_O && FLASH_WE_N_O)
    else $error("host drives during read");
  rdata_hold_a: assert property ($changed(RDATA_O) |-> DONE_O) else $error("read data moved");
endmodule

// ---- tb/nor_flash_model.sv ----
// behavioural flash: word array, command memory, program and erase
`timescale 1ns/100ps
module nor_flash_model #(
  parameter int          ADDR_W     = 26,
  parameter logic [15:0] PROG_CODE  = 16'h00a0,
  parameter logic [15:0] ERASE_CODE = 16'h0030,
  // stand-in status pattern, any value unlike the array data serves
  parameter logic [15:0] POLL_WORD  = 16'h0080,
  parameter int          BUSY_NS    = 300,
  parameter int          PROT_SECT  = 1
) (
  input  wire logic [ADDR_W-1:0] a_i,
  input  wire logic [15:0]       dq_i,
  input  wire logic              ce_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  output logic      [15:0]       dq_o
);
  // ****************************************
  // array and command memory
  // ****************************************
  // one 512-byte line of 256 words stands for the whole array
  logic [15:0]       mem [256];
  logic [ADDR_W-1:0] cmd_a;
  logic [15:0]       cmd_d;
  logic [15:0]       last;
  logic [15:0]       rd_w;
  logic              busy;
  logic              guard;
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    cmd_d = 16'h0000;
    last = 16'h0000;
    busy = 1'b0;
  end
  // released bus shows the inverse, so a stale sample cannot pass
  always @* begin
    if (ce_n_i || oe_n_i) rd_w = ~last;
    else if (busy) rd_w = POLL_WORD;
    else rd_w = mem[a_i[7:0]];
  end
  assign #15 dq_o = rd_w;
  always @(posedge oe_n_i) last = dq_o;
  always @(posedge we_n_i) begin
    guard = a_i[ADDR_W-1:16] == (ADDR_W-16)'(PROT_SECT);
    // a running algorithm takes no command at all here
    if (!ce_n_i && !busy) begin
      if (cmd_d == PROG_CODE && !guard) begin
        mem[a_i[7:0]] = mem[a_i[7:0]] & dq_i;
        busy = 1'b1;
        busy <= #(BUSY_NS) 1'b0;
      end else if (dq_i == ERASE_CODE && !guard) begin
        foreach (mem[i]) mem[i] = 16'hffff;
        busy = 1'b1;
        busy <= #(BUSY_NS) 1'b0;
      end
      cmd_a = a_i;
      cmd_d = dq_i;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// testbench: host controller against the behavioural flash
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        valid = 1'b0;
  logic        write = 1'b0;
  logic [25:0] addr = 26'h0;
  logic [15:0] wdata = 16'h0;
  logic        ready, done, dq_oe, ce_n, oe_n, we_n;
  logic [15:0] rdata, dq_o, dq_m, dq_w, lat;
  logic [25:0] fa;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  localparam logic [15:0] POLL_W = 16'h0080;
  always #20 clk = ~clk;
  assign dq_w = dq_oe ? dq_o : dq_m;
  nor_host_ctrl i_nor_host_ctrl (.CLK_I(clk), .RESET_N_I(rst_n), .CMD_VALID_I(valid),
    .CMD_WRITE_I(write), .CMD_ADDR_I(addr), .CMD_WDATA_I(wdata), .CMD_READY_O(ready),
    .DONE_O(done), .RDATA_O(rdata), .FLASH_A_O(fa), .FLASH_DQ_I(dq_w), .FLASH_DQ_O(dq_o),
    .FLASH_DQ_OE_O(dq_oe), .FLASH_CE_N_O(ce_n), .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n));
  nor_flash_model #(.POLL_WORD(POLL_W)) i_nor_flash_model (.a_i(fa), .dq_i(dq_w),
    .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .dq_o(dq_m));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [25:0] a, input logic [15:0] d);
    @(negedge clk);
    valid = 1'b1;
    write = wr;
    addr = a;
    wdata = d;
    do @(posedge clk); while (ready !== 1'b1);
    @(negedge clk);
    valid = 1'b0;
    lat = 16'h1;
    while (done !== 1'b1 && lat < 16'h40) begin
      @(negedge clk);
      lat++;
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk("rdata at reset", rdata, 16'hffff);
    @(negedge clk);
    chk("ready after reset", {15'h0, ready}, 16'h1);
  endtask
  task automatic t_read;
    xfer(1'b0, 26'h40, 16'h0);
    chk("erased word", rdata, 16'hffff);
    chk("miss latency", lat, 16'h14);
  endtask
  task automatic t_prog;
    xfer(1'b1, 26'h0, 16'h00a0);
    xfer(1'b1, 26'h45, 16'h1234);
    xfer(1'b0, 26'h45, 16'h0);
    chk("programmed word", rdata, 16'h1234);
    chk("refetch after write", lat, 16'h14);
    xfer(1'b0, 26'h4c, 16'h0);
    chk("page word", rdata, 16'hffff);
    chk("hit latency", lat, 16'h2);
    xfer(1'b0, 26'h55, 16'h0);
    chk("new page latency", lat, 16'h14);
  endtask
  task automatic t_erase;
    xfer(1'b1, 26'h0, 16'h00a0);
    xfer(1'b1, 26'h45, 16'hff0f);
    xfer(1'b0, 26'h45, 16'h0);
    chk("ones only to zeros", rdata, 16'h1204);
    xfer(1'b1, 26'h10040, 16'h0030);
    xfer(1'b0, 26'h10045, 16'h0);
    chk("guarded sector kept", rdata, 16'h1204);
    xfer(1'b1, 26'h40, 16'h0030);
    xfer(1'b0, 26'h45, 16'h0);
    chk("erased again", rdata, 16'hffff);
  endtask
  // reads and commands that land while an algorithm still runs
  task automatic t_poll;
    xfer(1'b1, 26'h0, 16'h00a0);
    xfer(1'b1, 26'h85, 16'h5a5a);
    xfer(1'b0, 26'h80, 16'h0);
    chk("status while busy", rdata, POLL_W);
    xfer(1'b0, 26'h85, 16'h0);
    chk("data after busy", rdata, 16'h5a5a);
    xfer(1'b1, 26'h0, 16'h00a0);
    xfer(1'b1, 26'h86, 16'h00ff);
    xfer(1'b1, 26'h40, 16'h0030);
    xfer(1'b0, 26'h85, 16'h0);
    chk("erase ignored while busy", rdata, 16'h5a5a);
    xfer(1'b0, 26'h86, 16'h0);
    chk("second program", rdata, 16'h00ff);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_read;
    t_prog;
    t_erase;
    t_poll;
    wrap_up;
  end
  // hang guard, far above the few hundred cycles used
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up;
    end
  end
endmodule
bind nor_host_ctrl nor_host_sva #(.ADDR_W(ADDR_W)) i_nor_host_sva (.*);
